// ### vdc_consts.svh
`ifndef VDC_CONSTS_SVH
`define VDC_CONSTS_SVH

// ==========================================================================
// register byte offsets in the device's i/o window
// ==========================================================================
`define VDC_A_LOOPBACK 8'h00
`define VDC_A_LCMD 8'h01
`define VDC_A_LSTAT 8'h03
`define VDC_A_AMOD 8'h04
`define VDC_A_VECTOR 8'h07
`define VDC_A_DCMD 8'h10
`define VDC_A_LADDR0 8'h11
`define VDC_A_LREM 8'h15
`define VDC_A_PKT 8'h16
`define VDC_A_RADDR0 8'h18
`define VDC_A_RREM 8'h1B

// ==========================================================================
// field positions
// ==========================================================================
`define VDC_DC_BLOCK 0
`define VDC_DC_DONE 1
`define VDC_DC_IRQEN 2
`define VDC_DC_PAUSE 3
`define VDC_DC_DIR 6
`define VDC_DC_START 7
`define VDC_LC_NOFWD 2
`define VDC_LC_NOVME 4
`define VDC_LB_MASK 8'h03
`define VDC_LS_ERR_MASK 8'hC4
`define VDC_LS_TMO_BIT 2
`define VDC_RADDR_LOW_W 12
`define VDC_PKT_LOG2 8

// ==========================================================================
// reset values
// ==========================================================================
`define VDC_BYTE_RST 8'h00
`define VDC_VEC_RST 8'hFF

// ==========================================================================
// sequence steps
// ==========================================================================
`define VDC_ST_CHECK 5'h00
`define VDC_ST_MODE 5'h01
`define VDC_ST_LADDR 5'h02
`define VDC_ST_RADDR 5'h06
`define VDC_ST_LREM 5'h09
`define VDC_ST_RREM 5'h0A
`define VDC_ST_PKT 5'h0B
`define VDC_ST_VEC 5'h0C
`define VDC_ST_LCMD 5'h0D
`define VDC_ST_AMOD 5'h0E
`define VDC_ST_RBACK 5'h0F
`define VDC_ST_START 5'h10
`define VDC_ST_STAT 5'h11
`define VDC_ST_ACK 5'h12
`define VDC_ST_FWD 5'h13

// ==========================================================================
// timing
// ==========================================================================
`define VDC_CLK_MHZ 250
`define VDC_WDOG_MS 16
`define VDC_WDOG_CYC (`VDC_WDOG_MS * 1000 * `VDC_CLK_MHZ)
`define VDC_POLL_NS 1000
`define VDC_POLL_CYC ((`VDC_POLL_NS * `VDC_CLK_MHZ + 999) / 1000)

`endif

// ### vdc_pkg.sv
package vdc_pkg;
	typedef logic [7:0] vdc_byte_t;
	typedef logic [4:0] vdc_step_t;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ISSUE,
		S_ACK,
		S_WAIT,
		S_END
	} vdc_state_e;
endpackage : vdc_pkg

// ### vdc_reg_port.sv
`timescale 1ns/1ns
`include "vdc_consts.svh"
module vdc_reg_port (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic req,
	input wire logic req_wr,
	input wire vdc_pkg::vdc_byte_t req_addr,
	input wire vdc_pkg::vdc_byte_t req_wdata,
	output logic done,
	output vdc_pkg::vdc_byte_t rdata,
	output vdc_pkg::vdc_byte_t dev_addr,
	output vdc_pkg::vdc_byte_t dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic dev_ack,
	input wire vdc_pkg::vdc_byte_t dev_rdata
);
	// ======================================================================
	// one byte access at a time, strobes held until the device answers
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_wr <= 1'b0;
			dev_rd <= 1'b0;
			dev_addr <= `VDC_BYTE_RST;
			dev_wdata <= `VDC_BYTE_RST;
			done <= 1'b0;
			rdata <= `VDC_BYTE_RST;
		end else begin
			done <= 1'b0;
			if (dev_wr || dev_rd) begin
				if (dev_ack) begin
					dev_wr <= 1'b0;
					dev_rd <= 1'b0;
					done <= 1'b1;
					rdata <= dev_rdata;
				end
			end else if (req) begin
				dev_wr <= req_wr;
				dev_rd <= !req_wr;
				dev_addr <= req_addr;
				dev_wdata <= req_wdata;
			end
		end
	end
endmodule : vdc_reg_port

// ### vdc_timer.sv
`timescale 1ns/1ns
module vdc_timer #(
	parameter int POLL_CYC = 250,
	parameter int WDOG_CYC = 4000000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic poll_clr,
	output logic poll_due,
	output logic wdog_exp
);
	logic [31:0] poll_cnt_reg;
	logic [31:0] wdog_cnt_reg;

	// ======================================================================
	// poll spacing: reading the command register too often slows the move
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			poll_cnt_reg <= 32'h0;
			poll_due <= 1'b0;
		end else if (!run || poll_clr) begin
			poll_cnt_reg <= 32'h0;
			poll_due <= 1'b0;
		end else if (poll_cnt_reg >= 32'(POLL_CYC - 1)) begin
			poll_due <= 1'b1;
		end else begin
			poll_cnt_reg <= poll_cnt_reg + 32'h1;
		end
	end

	// ======================================================================
	// watchdog over the whole transfer
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdog_cnt_reg <= 32'h0;
			wdog_exp <= 1'b0;
		end else if (!run) begin
			wdog_cnt_reg <= 32'h0;
			wdog_exp <= 1'b0;
		end else if (wdog_cnt_reg >= 32'(WDOG_CYC - 1)) begin
			wdog_exp <= 1'b1;
		end else begin
			wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
		end
	end
endmodule : vdc_timer

// ### vdc_host.sv
// Overview of operation
// R01 - local transfer address holds the VMEbus address of the first location
// R02 - remote address: low 12 bits address, upper field first mapping entry
// R03 - local remainder count gets transfer length modulo 256
// R04 - remote remainder count gets the same value as local remainder
// R05 - packet count gets transfer length divided by 256
// R06 - command written twice: mode without start, then same bits plus start
// R07 - start write is the readback of the command with start added
// R08 - block mode rearbitrates after 512 bytes D64 or 256 bytes D32
// R09 - pause mode rearbitrates after at most 64 bytes
// R10 - non-block mode rearbitrates after every single transfer
// R11 - set local command bit 2 before setting start
// R12 - address modifier matches address width and block mode bit; code writes usr_am as given, not derived from usr_block
// R13 - done interrupt on level 1 or 2 when enabled and jumpered
// R14 - done bit set at end whether successful or failed
// R15 - clearing the done bit acknowledges and withdraws the interrupt
// R16 - local command bit 4 set blocks the done interrupt
// R17 - clearing local bit 2 after completion forwards held interrupts
// R18 - no cable access by either side during a transfer
// R19 - after done, read local status to look for errors
// R20 - device flags interface timeout if transfer exceeds 16 ms
// R21 - never start a transfer while either loopback mode is on
// R22 - device moves packets times 256 plus remainder bytes
`timescale 1ns/1ns
`include "vdc_consts.svh"
module vdc_host #(
	parameter int LEN_W = 16,
	parameter int POLL_CYC = `VDC_POLL_CYC,
	parameter int WDOG_CYC = `VDC_WDOG_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic usr_start,
	input wire logic usr_dir,
	input wire logic usr_block,
	input wire logic usr_pause,
	input wire logic usr_irq_en,
	input wire logic [31:0] usr_vme_addr,
	input wire logic [11:0] usr_map_entry,
	input wire logic [11:0] usr_remote_addr,
	input wire logic [LEN_W-1:0] usr_length,
	input wire vdc_pkg::vdc_byte_t usr_am,
	input wire vdc_pkg::vdc_byte_t usr_vector,
	output logic usr_busy,
	output logic usr_done,
	output logic usr_refused,
	output logic usr_timeout,
	output logic usr_error,
	output vdc_pkg::vdc_byte_t usr_status,
	output vdc_pkg::vdc_byte_t dev_addr,
	output vdc_pkg::vdc_byte_t dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic dev_ack,
	input wire vdc_pkg::vdc_byte_t dev_rdata,
	input wire logic dev_irq_n
);
	vdc_pkg::vdc_state_e state_reg;
	vdc_pkg::vdc_step_t step_reg;
	logic poll_reg;
	logic xfer_reg;
	logic wdog_hit_reg;
	logic fwd_off_reg;
	vdc_pkg::vdc_byte_t mode_reg;
	vdc_pkg::vdc_byte_t rb_reg;
	vdc_pkg::vdc_byte_t am_reg;
	vdc_pkg::vdc_byte_t vec_reg;
	logic [31:0] laddr_reg;
	logic [23:0] raddr_reg;
	logic [LEN_W-1:0] len_reg;
	logic port_req;
	logic req_wr;
	vdc_pkg::vdc_byte_t req_addr;
	vdc_pkg::vdc_byte_t req_wdata;
	logic port_done;
	vdc_pkg::vdc_byte_t port_rdata;
	logic poll_due;
	logic wdog_exp;
	logic irq_seen;
	logic done_seen;
	vdc_pkg::vdc_byte_t mode_next;

	assign irq_seen = mode_reg[`VDC_DC_IRQEN] && !dev_irq_n;
	assign done_seen = port_done && poll_reg && port_rdata[`VDC_DC_DONE];

	// ======================================================================
	// mode byte: direction, block, pause, done interrupt; start kept clear
	// ======================================================================
	always_comb begin
		mode_next = `VDC_BYTE_RST;
		mode_next[`VDC_DC_DIR] = usr_dir;
		mode_next[`VDC_DC_BLOCK] = usr_block; // see R08 see R10
		mode_next[`VDC_DC_PAUSE] = usr_block && usr_pause; // see R09
		mode_next[`VDC_DC_IRQEN] = usr_irq_en; // see R13
	end

	// ======================================================================
	// order latch
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= `VDC_BYTE_RST;
			am_reg <= `VDC_BYTE_RST;
			vec_reg <= `VDC_VEC_RST;
			laddr_reg <= 32'h0;
			raddr_reg <= 24'h0;
			len_reg <= '0;
		end else if (state_reg == vdc_pkg::S_IDLE && usr_start) begin
			mode_reg <= mode_next;
			am_reg <= usr_am;
			vec_reg <= usr_vector;
			laddr_reg <= usr_vme_addr;
			raddr_reg <= {usr_map_entry, usr_remote_addr};
			len_reg <= usr_length;
		end
	end

	// ======================================================================
	// access of each step
	// ======================================================================
	always_comb begin
		req_wr = 1'b1;
		req_addr = `VDC_A_DCMD;
		req_wdata = `VDC_BYTE_RST;
		if (poll_reg) begin
			req_wr = 1'b0;
		end else begin
			case (step_reg)
				`VDC_ST_CHECK: begin
					req_wr = 1'b0;
					req_addr = `VDC_A_LOOPBACK;
				end
				`VDC_ST_MODE: begin
					req_wdata = mode_reg; // see R06
				end
				5'h02, 5'h03, 5'h04, 5'h05: begin
					req_addr = `VDC_A_LADDR0 + 8'(step_reg - `VDC_ST_LADDR);
					req_wdata = 8'(laddr_reg >> (8 * (step_reg - 5'h02))); // see R01
				end
				5'h06, 5'h07, 5'h08: begin
					req_addr = `VDC_A_RADDR0 + 8'(step_reg - `VDC_ST_RADDR);
					req_wdata = 8'(raddr_reg >> (8 * (step_reg - 5'h06))); // see R02
				end
				`VDC_ST_LREM: begin
					req_addr = `VDC_A_LREM;
					req_wdata = len_reg[7:0]; // see R03
				end
				`VDC_ST_RREM: begin
					req_addr = `VDC_A_RREM;
					req_wdata = len_reg[7:0]; // see R04
				end
				`VDC_ST_PKT: begin
					req_addr = `VDC_A_PKT;
					req_wdata = 8'(len_reg >> `VDC_PKT_LOG2); // see R05 see R22
				end
				`VDC_ST_VEC: begin
					req_addr = `VDC_A_VECTOR;
					req_wdata = vec_reg;
				end
				`VDC_ST_LCMD: begin
					// forwarding off, vme interrupts left open
					req_addr = `VDC_A_LCMD;
					req_wdata[`VDC_LC_NOFWD] = 1'b1; // see R11
					req_wdata[`VDC_LC_NOVME] = 1'b0; // see R16
				end
				`VDC_ST_AMOD: begin
					req_addr = `VDC_A_AMOD;
					req_wdata = am_reg; // see R12
				end
				`VDC_ST_RBACK: begin
					req_wr = 1'b0;
				end
				`VDC_ST_START: begin
					req_wdata = rb_reg | (8'h01 << `VDC_DC_START); // see R07
				end
				`VDC_ST_STAT: begin
					req_wr = 1'b0;
					req_addr = `VDC_A_LSTAT; // see R19
				end
				`VDC_ST_ACK: begin
					req_wdata = mode_reg; // see R15 see R14
				end
				`VDC_ST_FWD: begin
					req_addr = `VDC_A_LCMD;
					req_wdata = `VDC_BYTE_RST; // see R17
				end
				default: begin
					req_wr = 1'b0;
				end
			endcase
		end
	end

	assign port_req = state_reg == vdc_pkg::S_ISSUE;

	// ======================================================================
	// sequencer
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= vdc_pkg::S_IDLE;
			step_reg <= `VDC_ST_CHECK;
			poll_reg <= 1'b0;
			xfer_reg <= 1'b0;
			wdog_hit_reg <= 1'b0;
			rb_reg <= `VDC_BYTE_RST;
			usr_status <= `VDC_BYTE_RST;
			usr_refused <= 1'b0;
		end else begin
			case (state_reg)
				vdc_pkg::S_IDLE: begin
					if (usr_start) begin
						state_reg <= vdc_pkg::S_ISSUE;
						step_reg <= `VDC_ST_CHECK;
						wdog_hit_reg <= 1'b0;
						usr_refused <= 1'b0;
					end
				end
				vdc_pkg::S_ISSUE: begin
					state_reg <= vdc_pkg::S_ACK;
				end
				vdc_pkg::S_ACK: begin
					if (port_done) begin
						state_reg <= vdc_pkg::S_ISSUE;
						step_reg <= step_reg + 5'h01;
						if (poll_reg) begin
							poll_reg <= 1'b0;
							if (port_rdata[`VDC_DC_DONE]) begin
								xfer_reg <= 1'b0;
								step_reg <= `VDC_ST_STAT;
							end else begin
								state_reg <= vdc_pkg::S_WAIT;
								step_reg <= step_reg;
							end
						end else if (step_reg == `VDC_ST_CHECK &&
							(port_rdata & `VDC_LB_MASK) != 8'h00) begin
							state_reg <= vdc_pkg::S_END; // see R21
							usr_refused <= 1'b1;
						end else if (step_reg == `VDC_ST_RBACK) begin
							rb_reg <= port_rdata;
						end else if (step_reg == `VDC_ST_START) begin
							state_reg <= vdc_pkg::S_WAIT;
							xfer_reg <= 1'b1;
						end else if (step_reg == `VDC_ST_STAT) begin
							usr_status <= port_rdata;
						end else if (step_reg == `VDC_ST_FWD) begin
							state_reg <= vdc_pkg::S_END;
						end
					end
				end
				vdc_pkg::S_WAIT: begin
					// from here the done poll reads the command register at VDC_A_DCMD; watchdog expiry goes on to read local status at VDC_A_LSTAT
					if (wdog_exp) begin
						xfer_reg <= 1'b0;
						wdog_hit_reg <= 1'b1;
						step_reg <= `VDC_ST_STAT;
						state_reg <= vdc_pkg::S_ISSUE;
					end else if (irq_seen || poll_due) begin
						poll_reg <= 1'b1; // see R18
						state_reg <= vdc_pkg::S_ISSUE;
					end
				end
				vdc_pkg::S_END: begin
					state_reg <= vdc_pkg::S_IDLE;
				end
				default: begin
					state_reg <= vdc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// user-side flags
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			usr_busy <= 1'b0;
			usr_done <= 1'b0;
			usr_timeout <= 1'b0;
			usr_error <= 1'b0;
		end else begin
			usr_busy <= state_reg != vdc_pkg::S_IDLE ||
				(state_reg == vdc_pkg::S_IDLE && usr_start);
			usr_done <= state_reg == vdc_pkg::S_END;
			if (state_reg == vdc_pkg::S_END) begin
				usr_timeout <= wdog_hit_reg ||
					usr_status[`VDC_LS_TMO_BIT]; // see R20
				usr_error <= wdog_hit_reg || usr_refused ||
					(usr_status & `VDC_LS_ERR_MASK) != 8'h00;
			end
		end
	end

	// ======================================================================
	// helper for checks: forwarding state last written to local command
	// ======================================================================
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fwd_off_reg <= 1'b0;
		end else if (dev_wr && dev_ack && dev_addr == `VDC_A_LCMD) begin
			fwd_off_reg <= dev_wdata[`VDC_LC_NOFWD];
		end
	end

	vdc_reg_port u_port (
		.clk(clk),
		.arst_n(arst_n),
		.req(port_req),
		.req_wr(req_wr),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.done(port_done),
		.rdata(port_rdata),
		.dev_addr(dev_addr),
		.dev_wdata(dev_wdata),
		.dev_wr(dev_wr),
		.dev_rd(dev_rd),
		.dev_ack(dev_ack),
		.dev_rdata(dev_rdata)
	);

	vdc_timer #(
		.POLL_CYC(POLL_CYC),
		.WDOG_CYC(WDOG_CYC)
	) u_timer (
		.clk(clk),
		.arst_n(arst_n),
		.run(xfer_reg),
		.poll_clr(poll_reg),
		.poll_due(poll_due),
		.wdog_exp(wdog_exp)
	);

	// ======================================================================
	// checks
	// ======================================================================
	sequence s_done_seen;
		done_seen;
	endsequence

	sequence s_stat_read;
		dev_rd && dev_addr == `VDC_A_LSTAT;
	endsequence

	chk_lrem_value: assert property (@(posedge clk) disable iff (!arst_n) // see R03
		dev_wr && dev_addr == `VDC_A_LREM |-> dev_wdata == len_reg[7:0])
		else $error("local remainder not length modulo 256");
	chk_rrem_match: assert property (@(posedge clk) disable iff (!arst_n) // see R04
		dev_wr && dev_addr == `VDC_A_RREM |-> dev_wdata == len_reg[7:0])
		else $error("remote remainder differs from local");
	chk_pkt_value: assert property (@(posedge clk) disable iff (!arst_n) // see R05
		dev_wr && dev_addr == `VDC_A_PKT |->
		dev_wdata == 8'(len_reg >> `VDC_PKT_LOG2))
		else $error("packet count not length over 256");
	chk_mode_first: assert property (@(posedge clk) disable iff (!arst_n) // see R06
		port_req && !poll_reg && step_reg == `VDC_ST_MODE |->
		##1 dev_wr && !dev_wdata[`VDC_DC_START] && dev_wdata == mode_reg)
		else $error("first command write carries start");
	chk_start_rmw: assert property (@(posedge clk) disable iff (!arst_n) // see R07
		dev_wr && dev_addr == `VDC_A_DCMD && dev_wdata[`VDC_DC_START] |->
		dev_wdata == (rb_reg | 8'h80) && rb_reg[`VDC_DC_START] == 1'b0)
		else $error("start write is not readback plus start");
	chk_fwd_before: assert property (@(posedge clk) disable iff (!arst_n) // see R11
		dev_wr && dev_addr == `VDC_A_DCMD && dev_wdata[`VDC_DC_START] |->
		fwd_off_reg)
		else $error("start issued with forwarding enabled");
	chk_am_value: assert property (@(posedge clk) disable iff (!arst_n) // see R12
		dev_wr && dev_addr == `VDC_A_AMOD |-> dev_wdata == am_reg)
		else $error("address modifier mismatch");
	chk_no_cable: assert property (@(posedge clk) disable iff (!arst_n) // see R18
		xfer_reg && (dev_wr || dev_rd) |-> dev_rd && dev_addr == `VDC_A_DCMD)
		else $error("access other than done poll during transfer");
	chk_stat_after: assert property (@(posedge clk) disable iff (!arst_n) // see R19
		s_done_seen |-> ##[1:3] s_stat_read)
		else $error("status not read after done");
	chk_lb_guard: assert property (@(posedge clk) disable iff (!arst_n) // see R21
		port_done && !poll_reg && step_reg == `VDC_ST_CHECK &&
		(port_rdata & `VDC_LB_MASK) != 8'h00 |-> ##1 !dev_wr [*3])
		else $error("write issued while loopback is on");
	chk_done_clear: assert property (@(posedge clk) disable iff (!arst_n) // see R15
		port_req && !poll_reg && step_reg == `VDC_ST_ACK |->
		##1 dev_wr && dev_addr == `VDC_A_DCMD && !dev_wdata[`VDC_DC_DONE])
		else $error("done bit not cleared on acknowledge");
	chk_fwd_restore: assert property (@(posedge clk) disable iff (!arst_n) // see R17
		port_req && !poll_reg && step_reg == `VDC_ST_FWD |->
		##1 dev_wr && dev_addr == `VDC_A_LCMD && !dev_wdata[`VDC_LC_NOFWD])
		else $error("forwarding not restored after transfer");
endmodule : vdc_host

// ### vdc_dev_model.sv
`timescale 1ns/1ns
module vdc_dev_model #(
	parameter int TMO_CYC = 1000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire vdc_pkg::vdc_byte_t dev_addr,
	input wire vdc_pkg::vdc_byte_t dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	output logic dev_ack,
	output vdc_pkg::vdc_byte_t dev_rdata,
	output logic dev_irq_n,
	input wire logic [1:0] lat,
	input wire logic [1:0] lb_mode,
	input wire vdc_pkg::vdc_byte_t err_set,
	input wire logic hang,
	output logic [31:0] laddr,
	output logic [23:0] raddr,
	output logic [15:0] moved,
	output vdc_pkg::vdc_byte_t am,
	output vdc_pkg::vdc_byte_t vec,
	output vdc_pkg::vdc_byte_t mode,
	output vdc_pkg::vdc_byte_t fwd,
	output vdc_pkg::vdc_byte_t proto_err
);
	vdc_pkg::vdc_byte_t regs [0:31];
	vdc_pkg::vdc_byte_t stat;
	logic [1:0] wcnt;
	logic [11:0] run_cnt;
	logic busy;
	logic pend;
	logic tmo;
	logic [4:0] a;
	assign a = dev_addr[4:0];
	assign laddr = {regs[20], regs[19], regs[18], regs[17]};
	assign raddr = {regs[26], regs[25], regs[24]};
	assign moved = {regs[22], regs[21]};
	assign am = regs[4];
	assign vec = regs[7];
	assign tmo = (run_cnt == 12'(TMO_CYC));
	// jumper taken as fitted
	assign dev_irq_n = !(regs[16][1] && regs[16][2] && !regs[1][4]);
	// =====
	// register access and transfer engine
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= 8'h00;
			end
			regs[7] <= 8'hFF;
			{stat, mode, fwd, proto_err, dev_rdata} <= 40'h0;
			{wcnt, run_cnt, busy, pend, dev_ack} <= 17'h0;
		end else begin
			dev_ack <= 1'b0;
			// released data lines toggle every cycle instead of holding the last value
			dev_rdata <= ~dev_rdata;
			if ((dev_wr || dev_rd) && !dev_ack) begin
				wcnt <= wcnt + 2'h1;
				if (wcnt == lat) begin
					dev_ack <= 1'b1;
					wcnt <= 2'h0;
					if (dev_rd) begin
						dev_rdata <= (a == 5'h00) ? {6'h00, lb_mode} :
							(a == 5'h03) ? stat : regs[a];
					end else begin
						regs[a] <= dev_wdata;
						if (busy) begin
							proto_err <= proto_err + 8'h01;
						end
						if (a == 5'h10 && dev_wdata[7]) begin
							if (dev_wdata[6:0] != regs[16][6:0] || !regs[1][2] ||
								lb_mode != 2'h0 || regs[27] != regs[21]) begin
								proto_err <= proto_err + 8'h01;
							end
							busy <= 1'b1;
							run_cnt <= 12'h000;
							mode <= dev_wdata;
						end
						if (a == 5'h01 && !dev_wdata[2] && pend) begin
							fwd <= fwd + 8'h01;
							pend <= 1'b0;
						end
						if (a == 5'h01 && dev_wdata[7]) begin
							stat <= 8'h00;
						end
					end
				end
			end
			if (busy) begin
				run_cnt <= run_cnt + 12'h001;
				if ((!hang && run_cnt == {2'h0, moved[15:6]} + 12'h004) || tmo) begin
					busy <= 1'b0;
					regs[16] <= {1'b0, regs[16][6:2], 1'b1, regs[16][0]};
					stat <= stat | err_set | {5'h00, tmo, 2'h0};
					pend <= regs[1][2];
				end
			end
		end
	end
endmodule : vdc_dev_model

// ### vdc_host_bench.sv
`timescale 1ns/1ns
module vdc_host_bench;
	logic clk;
	logic arst_n;
	logic usr_start, usr_dir, usr_block, usr_pause, usr_irq_en;
	logic [31:0] usr_vme_addr;
	logic [11:0] usr_map_entry, usr_remote_addr;
	logic [15:0] usr_length;
	vdc_pkg::vdc_byte_t usr_am, usr_vector, usr_status, dev_addr, dev_wdata;
	vdc_pkg::vdc_byte_t dev_rdata, err_set, am, vec, mode, fwd, proto_err;
	logic usr_busy, usr_done, usr_refused, usr_timeout, usr_error;
	logic dev_wr, dev_rd, dev_ack, dev_irq_n, hang;
	logic [1:0] lat, lb_mode;
	logic [31:0] laddr;
	logic [23:0] raddr;
	logic [15:0] moved;
	vdc_pkg::vdc_byte_t exp_stat = 8'h00;
	int error_cnt = 0;
	int n_tests = 0;
	int irq_cnt = 0;
	vdc_host #(.LEN_W(16), .POLL_CYC(4), .WDOG_CYC(4000)) dut (.clk(clk),
		.arst_n(arst_n), .usr_start(usr_start), .usr_dir(usr_dir),
		.usr_block(usr_block), .usr_pause(usr_pause), .usr_irq_en(usr_irq_en),
		.usr_vme_addr(usr_vme_addr), .usr_map_entry(usr_map_entry),
		.usr_remote_addr(usr_remote_addr), .usr_length(usr_length),
		.usr_am(usr_am), .usr_vector(usr_vector), .usr_busy(usr_busy),
		.usr_done(usr_done), .usr_refused(usr_refused),
		.usr_timeout(usr_timeout), .usr_error(usr_error),
		.usr_status(usr_status), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_wr(dev_wr), .dev_rd(dev_rd), .dev_ack(dev_ack),
		.dev_rdata(dev_rdata), .dev_irq_n(dev_irq_n));
	vdc_dev_model #(.TMO_CYC(1000)) dev (.clk(clk), .arst_n(arst_n),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
		.dev_rd(dev_rd), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
		.dev_irq_n(dev_irq_n), .lat(lat), .lb_mode(lb_mode),
		.err_set(err_set), .hang(hang), .laddr(laddr), .raddr(raddr),
		.moved(moved), .am(am), .vec(vec), .mode(mode), .fwd(fwd),
		.proto_err(proto_err));
	always @(negedge dev_irq_n) irq_cnt++;
	// =====
	// helpers
	function automatic vdc_pkg::vdc_byte_t exp_mode(input logic d, b, p, q);
		return {1'b0, d, 2'h0, p & b, q, 1'b0, b};
	endfunction : exp_mode
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic run_one(input logic [15:0] len, input logic [1:0] lbm,
		input vdc_pkg::vdc_byte_t es, input logic hg);
		int n;
		int i0;
		vdc_pkg::vdc_byte_t f0;
		@(posedge clk);
		usr_length <= len;
		usr_vme_addr <= $urandom;
		usr_map_entry <= 12'($urandom);
		usr_remote_addr <= 12'($urandom);
		usr_am <= 8'($urandom);
		usr_vector <= 8'($urandom);
		{usr_dir, usr_block, usr_pause, usr_irq_en} <= 4'($urandom);
		lat <= 2'($urandom);
		lb_mode <= lbm;
		err_set <= es;
		hang <= hg;
		usr_start <= 1'b1;
		i0 = irq_cnt;
		f0 = fwd;
		// held one more edge: a start while busy must be ignored
		repeat (2) @(posedge clk);
		usr_start <= 1'b0;
		#1;
		chk(usr_busy, 1'b1);
		n = 0;
		while (usr_done !== 1'b1 && n < 8000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (lbm == 2'h0) begin
			exp_stat = exp_stat | es | (hg ? 8'h04 : 8'h00);
		end
		chk(usr_done, 1'b1);
		chk(usr_refused, lbm != 2'h0);
		if (lbm != 2'h0) begin
			chk(usr_error, 1'b1);
		end else begin
			chk(mode, exp_mode(usr_dir, usr_block, usr_pause,
				usr_irq_en) | 8'h80);
			chk(laddr, usr_vme_addr);
			chk(raddr, {usr_map_entry, usr_remote_addr});
			chk(moved, len);
			chk(am, usr_am);
			chk(vec, usr_vector);
			chk(usr_status, exp_stat);
			chk(usr_error, |(exp_stat & 8'hC4));
			chk(usr_timeout, exp_stat[2]);
			chk(irq_cnt - i0, usr_irq_en);
			chk(fwd - f0, 1);
		end
		chk(dev_irq_n, 1'b1);
		chk(proto_err, 0);
		// one cycle after the done pulse the order port is free again
		@(posedge clk);
		#1;
		chk(usr_busy, 1'b0);
	endtask : run_one
	// =====
	// clock, watchdog, sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		arst_n = 1'b0;
		{usr_start, usr_dir, usr_block, usr_pause, usr_irq_en, hang} = 6'h0;
		{usr_vme_addr, usr_map_entry, usr_remote_addr, usr_length} = 72'h0;
		{usr_am, usr_vector, err_set, lat, lb_mode} = 28'h0;
		void'($urandom(99382));
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		run_one(16'h0000, 2'h0, 8'h00, 1'b0);
		run_one(16'h0100, 2'h0, 8'h00, 1'b0);
		run_one(16'h3FFF, 2'h0, 8'h00, 1'b0);
		for (int i = 0; i < 20; i++) begin
			run_one(16'($urandom_range(1, 16'h3FFF)), 2'h0, 8'h00, 1'b0);
		end
		for (int i = 1; i < 4; i++) begin
			run_one(16'h0100, 2'(i), 8'h00, 1'b0);
		end
		run_one(16'h0040, 2'h0, 8'h40, 1'b0);
		run_one(16'h0200, 2'h0, 8'h00, 1'b1);
		report_and_stop();
	end
endmodule : vdc_host_bench
